// *** hdl/ucode_store.sv ***
// Writeable microcode store: 24 nibble memories forming 96-bit words.
// Assumes the host loader drives address, lane, byte and write line from
// flops on clk_i, and the sequencer address arrives on the same clock.
`timescale 1ns/10ps
module ucode_store (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire ucode_pkg::host_req_s host_i,
  input wire logic [ucode_pkg::ADDR_W-1:0] seq_addr_i,
  output logic seq_addr_oe_o,
  output logic [ucode_pkg::WORD_W-1:0] microword_o,
  output logic [ucode_pkg::LANES-1:0] lane_we_n_o,
  output logic byte_done_o,
  output logic load_mode_o
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  // Async assert, synchronous release through two flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    ucode_pkg::phase_e phase;
    logic wr_line;
    logic done;
    logic [ucode_pkg::WORD_W-1:0] pipe;
  } top_state_s;
  top_state_s st_q;
  top_state_s st_d;

  // Lane decoder, one-hot active low; codes 12..15 select nothing
  function automatic logic [ucode_pkg::LANES-1:0] lane_decode(
    input logic [ucode_pkg::LANE_SEL_W-1:0] sel, input logic wr_n);
    logic [ucode_pkg::LANES-1:0] res;
    res = '1;
    if (!wr_n && sel < ucode_pkg::LANE_SEL_W'(ucode_pkg::LANES)) begin
      res[sel] = 1'b0;
    end
    return res;
  endfunction : lane_decode

  // ----------------------------------------------------------------------
  // Address and strobes
  // ----------------------------------------------------------------------
  logic [ucode_pkg::ADDR_W-1:0] ram_addr;
  logic [ucode_pkg::LANES-1:0] lane_we_n;
  logic [ucode_pkg::WORD_W-1:0] ram_dout;
  logic [ucode_pkg::CHIPS-1:0] ram_oe;
  // Per-chip strobe, so checks can look at each chip of a pair
  logic [ucode_pkg::CHIPS-1:0] chip_we;

  // Mode picks the driver of the shared address lines
  assign ram_addr = host_i.load_mode ? host_i.addr : seq_addr_i;
  assign seq_addr_oe_o = !host_i.load_mode;
  assign load_mode_o = host_i.load_mode;
  // Strobes only in load mode; run mode reads keep them high
  assign lane_we_n = lane_decode(host_i.lane,
                                 !(host_i.load_mode && !host_i.write_line));
  assign lane_we_n_o = lane_we_n;

  // ----------------------------------------------------------------------
  // Memory array: 24 chips in 12 byte lanes
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < ucode_pkg::CHIPS; c++) begin : g_chip
    // Both chips of a lane see the same strobe
    assign chip_we[c] = !lane_we_n[c/2];
    nibble_ram u_ram (
      .clk_i(clk_i),
      .rst_ni(rst_n),
      .cs_ni(1'b0), // Select tied active
      .we_ni(lane_we_n[c/2]), // Two chips per lane
      .addr_i(ram_addr),
      // Even chip low nibble, odd chip high nibble
      .din_i(host_i.data[(c%2)*4 +: 4]),
      .dout_o(ram_dout[c*4 +: 4]),
      .dout_oe_o(ram_oe[c])
    );
  end

  // ----------------------------------------------------------------------
  // Commit tracking and pipeline
  // ----------------------------------------------------------------------
  // Byte commit seen as high-low-high on the write line
  always_comb begin
    st_d = st_q;
    st_d.wr_line = host_i.write_line;
    st_d.done = 1'b0;
    case (st_q.phase)
      ucode_pkg::PH_IDLE: begin
        if (host_i.load_mode && st_q.wr_line && !host_i.write_line) begin
          st_d.phase = ucode_pkg::PH_LOW;
        end
      end
      ucode_pkg::PH_LOW: begin
        if (host_i.write_line) begin
          st_d.phase = ucode_pkg::PH_DONE;
          st_d.done = 1'b1;
        end
      end
      ucode_pkg::PH_DONE: st_d.phase = ucode_pkg::PH_IDLE;
      default: st_d.phase = ucode_pkg::PH_IDLE;
    endcase
    // Pipeline captures the fetched word in run mode only
    if (!host_i.load_mode) begin
      st_d.pipe = ram_dout;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{phase: ucode_pkg::PH_IDLE, wr_line: 1'b1, done: 1'b0,
                pipe: ucode_pkg::WORD_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign microword_o = st_q.pipe;
  assign byte_done_o = st_q.done;

  // ----------------------------------------------------------------------
  // Checks: strobes and lanes
  // ----------------------------------------------------------------------
  // Run mode fetches are pure reads
  run_no_strobe_a: assert property (@(posedge clk_i)
    disable iff (!rst_n) !host_i.load_mode |-> lane_we_n == '1)
    else $error("strobe active in run mode");
  // Two lanes at once would overwrite a neighbour byte
  one_lane_a: assert property (@(posedge clk_i)
    disable iff (!rst_n) $countones(~lane_we_n) <= 1)
    else $error("several lanes strobed");
  // In load mode, a valid lane code with the line low strobes that lane alone
  lane_pick_a: assert property (@(posedge clk_i)
    disable iff (!rst_n)
    (host_i.load_mode && !host_i.write_line &&
     host_i.lane < ucode_pkg::LANE_SEL_W'(ucode_pkg::LANES))
      |-> lane_we_n == ~(ucode_pkg::LANES'(1'b1) << host_i.lane))
    else $error("wrong lane strobed");
  // Codes above the last lane write nothing at all
  lane_spare_a: assert property (@(posedge clk_i)
    disable iff (!rst_n)
    host_i.lane >= ucode_pkg::LANE_SEL_W'(ucode_pkg::LANES)
      |-> lane_we_n == '1)
    else $error("spare lane code strobed");
  // Chips being written keep their outputs off; others may still drive
  no_contend_a: assert property (@(posedge clk_i)
    disable iff (!rst_n) (lane_we_n != '1) |-> (ram_oe & chip_we) == '0)
    else $error("memory drives during write");

  // ----------------------------------------------------------------------
  // Checks: address routing and pipeline
  // ----------------------------------------------------------------------
  // Loader owns the address lines while loading
  addr_route_a: assert property (@(posedge clk_i)
    disable iff (!rst_n)
    host_i.load_mode |-> (ram_addr == host_i.addr && !seq_addr_oe_o))
    else $error("wrong address source");
  // Sequencer owns them again in run mode
  run_route_a: assert property (@(posedge clk_i)
    disable iff (!rst_n)
    !host_i.load_mode |-> (ram_addr == seq_addr_i && seq_addr_oe_o))
    else $error("sequencer address not used");
  // Pipeline takes the word fetched one edge earlier
  pipe_follows_a: assert property (@(posedge clk_i)
    disable iff (!rst_n)
    (!host_i.load_mode ##1 !host_i.load_mode) |->
      microword_o == $past(ram_dout))
    else $error("pipeline stale");
  // Loading leaves the last executed word in place
  pipe_hold_a: assert property (@(posedge clk_i)
    disable iff (!rst_n) host_i.load_mode |=> $stable(microword_o))
    else $error("pipeline changed while loading");

  // ----------------------------------------------------------------------
  // Checks: byte commit
  // ----------------------------------------------------------------------
  // Commit flag is a single-cycle pulse
  commit_pulse_a: assert property (@(posedge clk_i)
    disable iff (!rst_n) byte_done_o |-> ##1 !byte_done_o)
    else $error("commit too long");
  // Line rising after its low phase reports the commit next cycle
  commit_seen_a: assert property (@(posedge clk_i)
    disable iff (!rst_n)
    (st_q.phase == ucode_pkg::PH_LOW && host_i.write_line) |=> byte_done_o)
    else $error("commit not reported");
  // No commit without a preceding low phase
  commit_cause_a: assert property (@(posedge clk_i)
    disable iff (!rst_n)
    byte_done_o |-> $past(st_q.phase) == ucode_pkg::PH_LOW)
    else $error("commit without low phase");

endmodule : ucode_store

// *** hdl/ucode_pkg.sv ***
// Shared constants and carrier types for the microcode store and its loader.
// Assumes a single 20 MHz clock domain; all users reference names with ::.
package ucode_pkg;

  // ----------------------------------------------------------------------
  // Store geometry
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DEPTH = 4096;
  localparam int unsigned NIBBLE_W = 4;
  localparam int unsigned CHIPS = 24;
  localparam int unsigned WORD_W = 96;
  localparam int unsigned LANES = 12;
  localparam int unsigned LANE_SEL_W = 4;
  localparam int unsigned BYTE_W = 8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [LANE_SEL_W-1:0] LANE_RST = 4'h0;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 96'h0000_0000_0000_0000_0000_0000;

  // Loader phases of one byte commit
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_LOW = 2'b01,
    PH_DONE = 2'b10
  } phase_e;

  // Host-side request carrier
  typedef struct packed {
    logic load_mode;
    logic write_line;
    logic [LANE_SEL_W-1:0] lane;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } host_req_s;

endpackage : ucode_pkg

// *** hdl/nibble_ram.sv ***
// One separate-input/output 4-bit static memory of 4K words.
// Assumes synchronous strobes on clk_i; the write is the overlap of
// active-low select and strobe, sampled at each rising edge.
`timescale 1ns/10ps
module nibble_ram (
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic cs_ni,
  input wire logic we_ni,
  input wire logic [ucode_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ucode_pkg::NIBBLE_W-1:0] din_i,
  output logic [ucode_pkg::NIBBLE_W-1:0] dout_o,
  output logic dout_oe_o
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [ucode_pkg::NIBBLE_W-1:0] mem [ucode_pkg::DEPTH];

  typedef struct packed {
    logic cs_n;
    logic we_n;
  } ram_state_s;
  ram_state_s st_q;
  ram_state_s st_d;

  // Track strobes to tell which edge ended a write
  always_comb begin
    st_d = st_q;
    st_d.cs_n = cs_ni;
    st_d.we_n = we_ni;
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  // Write only during the overlap of both lows
  always_ff @(posedge clk_i) begin
    if (!cs_ni && !we_ni) begin
      mem[addr_i] <= din_i;
    end
  end

  // Separate outputs always carry the addressed nibble
  assign dout_o = mem[addr_i];
  // Outputs stay off through any write overlap
  assign dout_oe_o = !cs_ni && we_ni;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  no_drive_write_a: assert property (@(posedge clk_i)
    disable iff (!rst_ni) !we_ni |-> !dout_oe_o)
    else $error("outputs on during write");
  end_write_hiz_a: assert property (@(posedge clk_i)
    disable iff (!rst_ni) (!st_q.we_n && cs_ni) |-> !dout_oe_o)
    else $error("outputs on at write end");

endmodule : nibble_ram

// *** testbench/host_loader_model.sv ***
// Host loader model: drives the store's host request and sequencer lines.
// Assumes the bench calls its tasks; all changes land on the falling edge.
`timescale 1ns/10ps
module host_loader_model (
  input wire logic clk_i,
  input wire logic byte_done_i,
  input wire logic [11:0] lane_we_n_i,
  input wire logic [95:0] microword_i,
  output ucode_pkg::host_req_s host_o,
  output logic [11:0] seq_addr_o
);
  logic [11:0] seq_q = 12'h000;
  logic flip = 1'b0;

  // ----------------------------------------------------------------
  // Sequencer side
  // ----------------------------------------------------------------
  // Disabled sequencer alternates each cycle between the inverted and the stale address
  always @(negedge clk_i) flip <= ~flip;
  assign seq_addr_o = host_o.load_mode ? ~seq_q ^ {12{flip}} : seq_q;

  initial begin
    host_o = '{1'b1, 1'b1, 4'h0, 12'h000, 8'h00};
  end

  // One byte commit: set up, drop the write line one cycle, raise it
  task automatic write_byte(input logic m, input logic [11:0] a,
    input logic [3:0] ln, input logic [7:0] d,
    output logic [11:0] st, output logic [1:0] np);
    @(negedge clk_i);
    host_o = '{m, 1'b1, ln, a, d};
    @(negedge clk_i);
    host_o.write_line = 1'b0;
    #1 st = lane_we_n_i;
    @(negedge clk_i);
    host_o.write_line = 1'b1;
    np = 2'd0;
    repeat (3) begin
      @(posedge clk_i);
      #1 np = np + {1'b0, byte_done_i};
    end
  endtask : write_byte

  // Run mode fetch; word is taken after the capturing edge
  task automatic read_word(input logic [11:0] a, output logic [95:0] w);
    @(negedge clk_i);
    host_o.load_mode = 1'b0;
    host_o.write_line = 1'b1;
    seq_q = a;
    @(negedge clk_i);
    w = microword_i;
  endtask : read_word
endmodule : host_loader_model

// *** testbench/tb_ucode_store.sv ***
// Bench for the microcode store: byte loads, run-mode fetch, refusals.
// Assumes the host model file is compiled first; 20 MHz clock.
`timescale 1ns/10ps
module tb_ucode_store;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  ucode_pkg::host_req_s host;
  logic [11:0] seq;
  logic [11:0] we_n;
  logic [95:0] word;
  logic oe, done, lm;
  logic [95:0] exp_q [logic [11:0]];
  int err_count = 0;
  int tests_run = 0;

  ucode_store ucode_store_i (.clk_i(clk_i), .nrst_i(nrst_i), .host_i(host),
    .seq_addr_i(seq), .seq_addr_oe_o(oe), .microword_o(word),
    .lane_we_n_o(we_n), .byte_done_o(done), .load_mode_o(lm));
  host_loader_model host_loader_model_i (.clk_i(clk_i), .byte_done_i(done),
    .lane_we_n_i(we_n), .microword_i(word), .host_o(host),
    .seq_addr_o(seq));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // All 16 lane codes; 12..15 carry data that must land nowhere
  task automatic load_word(input logic [11:0] a);
    logic [11:0] st;
    logic [1:0] np;
    logic [7:0] d;
    logic [11:0] exp_st;
    for (int k = 0; k < 16; k++) begin
      d = {k[3:0] ^ a[11:8], ~k[3:0] ^ a[3:0]};
      host_loader_model_i.write_byte(1'b1, a, k[3:0], d, st, np);
      if (k < 12) begin
        exp_q[a][8*k +: 8] = d;
        exp_st = ~(12'h001 << k);
        check(st, exp_st);
        check(np, 2'd1);
      end else begin
        check(st, 12'hFFF);
      end
    end
    check(lm, 1'b1);
    check(oe, 1'b0);
  endtask : load_word

  task automatic read_check(input logic [11:0] a);
    logic [95:0] w;
    host_loader_model_i.read_word(a, w);
    check(w, exp_q[a]);
    check(oe, 1'b1);
    check(lm, 1'b0);
  endtask : read_check

  // Lowest, highest and a middle word, read back out of order
  task automatic fill_edges;
    load_word(12'h000);
    load_word(12'hFFF);
    load_word(12'h5A5);
    read_check(12'hFFF);
    read_check(12'h000);
    read_check(12'h5A5);
  endtask : fill_edges

  // Strobe in run mode must write nothing
  task automatic run_refused;
    logic [11:0] st;
    logic [1:0] np;
    host_loader_model_i.write_byte(1'b0, 12'h000, 4'h0, 8'hFF, st, np);
    check(st, 12'hFFF);
    check(np, 2'd0);
    read_check(12'h000);
  endtask : run_refused

  // Rewrite end lanes only; nibble halves must land in place
  task automatic lane_rewrite;
    logic [11:0] st;
    logic [1:0] np;
    host_loader_model_i.write_byte(1'b1, 12'hFFF, 4'hB, 8'hC3, st, np);
    check(st, 12'h7FF);
    host_loader_model_i.write_byte(1'b1, 12'hFFF, 4'h0, 8'h96, st, np);
    check(st, 12'hFFE);
    exp_q[12'hFFF][95:88] = 8'hC3;
    exp_q[12'hFFF][7:0] = 8'h96;
    read_check(12'hFFF);
  endtask : lane_rewrite

  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(negedge clk_i);
    check(word, 96'h0);
    check(done, 1'b0);
    @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    fill_edges();
    run_refused();
    lane_rewrite();
    report_and_stop();
  end
endmodule : tb_ucode_store
